// file: hsc_pkg.sv
// package of the high-speed pulse counter unit: register map, field layout, modes
// assumes a 32-bit apb slave at 100 mhz and four synchronous digital count inputs
package hsc_pkg;

    // =====================================================================
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int PULSE_MAX_HZ = 50_000; // 32/16-bit counter input rate
    localparam int TRACK_MAX_HZ = 40_000; // quadrature track rate
    localparam int PULSE_PERIOD_CYC = CLK_HZ / PULSE_MAX_HZ;
    localparam int TRACK_PERIOD_CYC = CLK_HZ / TRACK_MAX_HZ;

    // =====================================================================
    // register byte offsets
    localparam logic [11:0] OFF_CONFIG = 12'h000;
    localparam logic [11:0] OFF_CTRL_IMAGE = 12'h004;
    localparam logic [11:0] OFF_CTRL_DIRECT = 12'h008;
    localparam logic [11:0] OFF_COMMIT = 12'h00C;
    localparam logic [11:0] OFF_PRESET32 = 12'h010;
    localparam logic [11:0] OFF_PRESET16 = 12'h014;
    localparam logic [11:0] OFF_HOME_VALUE = 12'h018;
    localparam logic [11:0] OFF_VALUE32 = 12'h01C;
    localparam logic [11:0] OFF_VALUE16 = 12'h020;
    localparam logic [11:0] OFF_QUAD_VALUE = 12'h024;
    localparam logic [11:0] OFF_STATUS = 12'h028;

    // =====================================================================
    // config fields
    localparam int CFG_W = 10;
    localparam int CFG_MODE_LSB = 0; // two bits
    localparam int CFG_EN_LSB = 2; // three bits, one per counter
    localparam int CFG_REPEAT = 5;
    localparam int CFG_WIN_SRC = 6;
    localparam int CFG_IRQ_EN_LSB = 7; // three bits
    localparam logic [CFG_W-1:0] CFG_RESET = 10'h000;

    // =====================================================================
    // control fields: counter k owns bits 3k..3k+2
    localparam int CTRL_W = 13;
    localparam int CTRL_EN = 0;
    localparam int CTRL_DIR = 1;
    localparam int CTRL_CLR = 2;
    localparam int CTRL_HOME_STROBE = 9;
    localparam int CTRL_ZERO_ACK = 10;
    localparam int CTRL_WIN_OPEN = 11;
    localparam int CTRL_QUAD_RUN = 12;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;

    // status fields
    localparam int ST_ZERO = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_DONE = 2;

    // input pin order in the synchroniser vectors
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_MARK = 2;
    localparam int PIN_HOME = 3;

    typedef enum logic [1:0] {
        HSC_MODE_C32 = 2'h0,
        HSC_MODE_C16 = 2'h1,
        HSC_MODE_QUAD = 2'h2
    } hsc_mode_t;

endpackage : hsc_pkg

// file: hsc_cnt_if.sv
// link between the unit top and one up/down counter core
// assumes both ends on pclk; the counter width is the parameter
`timescale 1ns/1ns
`default_nettype none
interface hsc_cnt_if #(parameter int W = 16) ();
    logic en;
    logic clr;
    logic dir;
    logic pulse;
    logic [W-1:0] preset;
    logic [W-1:0] value;
    logic cmp;
    modport ctl (output en, output clr, output dir, output pulse, output preset,
        input value, input cmp);
    modport cnt (input en, input clr, input dir, input pulse, input preset,
        output value, output cmp);
endinterface : hsc_cnt_if
`default_nettype wire

// file: hsc_updown.sv
// up/down counter core with preset compare, used at 32 and 16 bits
// assumes pulse is a one-cycle strobe already synchronised to pclk
`timescale 1ns/1ns
`default_nettype none
module hsc_updown (
    input wire logic pclk,
    input wire logic presetn,
    hsc_cnt_if.cnt bus
);
    localparam int W = $bits(bus.value);

    typedef struct packed {
        logic [W-1:0] value;
        logic [W-1:0] preset;
        logic dir;
        logic en_prev;
        logic clr_prev;
        logic cmp;
    } hsc_cnt_st_t;

    hsc_cnt_st_t r;
    hsc_cnt_st_t next_r;
    logic capture;

    // =====================================================================
    // next state
    assign capture = (bus.en && !r.en_prev) || (bus.clr && !r.clr_prev);

    always_comb begin
        next_r = r;
        next_r.cmp = 1'b0;
        next_r.en_prev = bus.en;
        next_r.clr_prev = bus.clr;
        if (capture) begin
            // clear and latch direction and preset
            next_r.value = '0;
            next_r.dir = bus.dir;
            next_r.preset = bus.preset;
        end else if (bus.en && bus.pulse) begin
            if (!r.dir) begin
                next_r.value = (r.value == r.preset) ? '0 : r.value + 1'b1;
            end else begin
                next_r.value = (r.value == '0) ? r.preset : r.value - 1'b1;
            end
            next_r.cmp = (next_r.value == r.preset);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign bus.value = r.value;
    assign bus.cmp = r.cmp;

    // =====================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_enable_clear: assert property ($rose(bus.en) |=> r.value == '0)
        else $error("enable edge did not clear value");
    chk_reset_clear: assert property (bus.clr && !r.clr_prev |=> r.value == '0)
        else $error("reset edge did not clear value");
    chk_disabled_hold: assert property (!bus.en && !capture |=> $stable(r.value))
        else $error("value moved while disabled");
    chk_up_wrap: assert property (bus.en && bus.pulse && !capture && !r.dir
        && r.value == r.preset |=> r.value == '0)
        else $error("up count did not restart at zero");
    chk_down_reload: assert property (bus.en && bus.pulse && !capture && r.dir
        && r.value == '0 |=> r.value == $past(r.preset) && r.cmp)
        else $error("down count did not reload preset");
    chk_cmp_equal: assert property (r.cmp |-> r.value == r.preset)
        else $error("compare pulse without equality");
    cov_up_wrap: cover property (r.cmp && !r.dir ##[1:20] r.value == '0);
    cov_down_reload: cover property (r.cmp && r.dir);
endmodule : hsc_updown
`default_nettype wire

// file: hsc_top.sv
// high-speed pulse counter unit: apb registers, 32/16-bit counters, quadrature counter
// assumes pclk at 100 mhz, inputs stable per pclk sample, apb master per amba rules
`timescale 1ns/1ns
`default_nettype none
module hsc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pulse_input_a,
    input wire logic pulse_input_b,
    input wire logic marker_pulse_input,
    input wire logic home_switch_input,
    output logic [2:0] cmp_irq
);
    typedef struct packed {
        logic [hsc_pkg::CFG_W-1:0] cfg;
        logic [hsc_pkg::CTRL_W-1:0] image;
        logic [hsc_pkg::CTRL_W-1:0] ctl;
        logic [31:0] preset32;
        logic [31:0] preset16;
        logic [31:0] home_val;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [31:0] quad;
        logic zero;
        logic win_prev;
        logic loaded;
        logic complete;
        logic strobe_prev;
        logic ack_prev;
        logic [2:0] irq;
    } hsc_top_st_t;

    hsc_top_st_t r;
    hsc_top_st_t next_r;

    hsc_cnt_if #(.W(32)) c32_if ();
    hsc_cnt_if #(.W(16)) c16a_if ();
    hsc_cnt_if #(.W(16)) c16b_if ();

    hsc_pkg::hsc_mode_t mode;
    logic [3:0] rise;
    logic ap_access;
    logic ap_write;
    logic window;
    logic marker_hit;
    logic step;
    logic step_up;
    logic [31:0] rd_word;
    logic [2:0] armed_cnt;

    // =====================================================================
    // decode helpers
    function automatic logic addr_ok(input logic [11:0] a);
        case (a)
            hsc_pkg::OFF_CONFIG, hsc_pkg::OFF_CTRL_IMAGE, hsc_pkg::OFF_CTRL_DIRECT,
            hsc_pkg::OFF_COMMIT, hsc_pkg::OFF_PRESET32, hsc_pkg::OFF_PRESET16,
            hsc_pkg::OFF_HOME_VALUE, hsc_pkg::OFF_VALUE32, hsc_pkg::OFF_VALUE16,
            hsc_pkg::OFF_QUAD_VALUE, hsc_pkg::OFF_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction : addr_ok

    // enable of counter k: control bit, config bit and matching mode
    function automatic logic cnt_enable(input logic [hsc_pkg::CTRL_W-1:0] c,
        input logic [hsc_pkg::CFG_W-1:0] g, input int k, input logic mode_hit);
        cnt_enable = c[3*k+hsc_pkg::CTRL_EN] && g[hsc_pkg::CFG_EN_LSB+k] && mode_hit;
    endfunction : cnt_enable

    // =====================================================================
    // input edges and apb qualifiers
    assign mode = hsc_pkg::hsc_mode_t'(r.cfg[hsc_pkg::CFG_MODE_LSB +: 2]);
    assign rise = r.sync2 & ~r.prev;
    assign ap_access = psel && penable && !r.pready;
    assign ap_write = psel && penable && pwrite && r.pready;

    // =====================================================================
    // counter cores
    assign c32_if.en = cnt_enable(r.ctl, r.cfg, 0, mode == hsc_pkg::HSC_MODE_C32);
    assign c32_if.clr = r.ctl[hsc_pkg::CTRL_CLR];
    assign c32_if.dir = r.ctl[hsc_pkg::CTRL_DIR];
    assign c32_if.preset = r.preset32;
    assign c32_if.pulse = rise[hsc_pkg::PIN_A];

    assign c16a_if.en = cnt_enable(r.ctl, r.cfg, 1, mode == hsc_pkg::HSC_MODE_C16);
    assign c16a_if.clr = r.ctl[3+hsc_pkg::CTRL_CLR];
    assign c16a_if.dir = r.ctl[3+hsc_pkg::CTRL_DIR];
    assign c16a_if.preset = r.preset16[15:0];
    assign c16a_if.pulse = rise[hsc_pkg::PIN_A];

    assign c16b_if.en = cnt_enable(r.ctl, r.cfg, 2, mode == hsc_pkg::HSC_MODE_C16);
    assign c16b_if.clr = r.ctl[6+hsc_pkg::CTRL_CLR];
    assign c16b_if.dir = r.ctl[6+hsc_pkg::CTRL_DIR];
    assign c16b_if.preset = r.preset16[31:16];
    assign c16b_if.pulse = rise[hsc_pkg::PIN_B];

    hsc_updown u_c32 (
        .pclk(pclk),
        .presetn(presetn),
        .bus(c32_if)
    );

    hsc_updown u_c16a (
        .pclk(pclk),
        .presetn(presetn),
        .bus(c16a_if)
    );

    hsc_updown u_c16b (
        .pclk(pclk),
        .presetn(presetn),
        .bus(c16b_if)
    );

    // =====================================================================
    // quadrature decode and homing window
    // one track changing alone is a step; both at once is a lost step, dropped
    assign step = (mode == hsc_pkg::HSC_MODE_QUAD) && r.ctl[hsc_pkg::CTRL_QUAD_RUN]
        && ((r.sync2[hsc_pkg::PIN_A] ^ r.prev[hsc_pkg::PIN_A])
        ^ (r.sync2[hsc_pkg::PIN_B] ^ r.prev[hsc_pkg::PIN_B]));
    assign step_up = r.sync2[hsc_pkg::PIN_A] ^ r.prev[hsc_pkg::PIN_B];
    assign window = r.cfg[hsc_pkg::CFG_WIN_SRC] ? r.ctl[hsc_pkg::CTRL_WIN_OPEN]
        : r.sync2[hsc_pkg::PIN_HOME];
    assign marker_hit = (mode == hsc_pkg::HSC_MODE_QUAD) && window && rise[hsc_pkg::PIN_MARK]
        && (r.cfg[hsc_pkg::CFG_REPEAT] || !r.loaded);

    // =====================================================================
    // read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            hsc_pkg::OFF_CONFIG: rd_word[hsc_pkg::CFG_W-1:0] = r.cfg;
            hsc_pkg::OFF_CTRL_IMAGE: rd_word[hsc_pkg::CTRL_W-1:0] = r.image;
            hsc_pkg::OFF_CTRL_DIRECT: rd_word[hsc_pkg::CTRL_W-1:0] = r.ctl;
            hsc_pkg::OFF_PRESET32: rd_word = r.preset32;
            hsc_pkg::OFF_PRESET16: rd_word = r.preset16;
            hsc_pkg::OFF_HOME_VALUE: rd_word = r.home_val;
            hsc_pkg::OFF_VALUE32: rd_word = c32_if.value;
            hsc_pkg::OFF_VALUE16: rd_word = {c16b_if.value, c16a_if.value};
            hsc_pkg::OFF_QUAD_VALUE: rd_word = r.quad;
            hsc_pkg::OFF_STATUS: begin
                rd_word[hsc_pkg::ST_ZERO] = r.zero;
                rd_word[hsc_pkg::ST_ARMED] = window && !r.complete;
                rd_word[hsc_pkg::ST_DONE] = r.complete;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // =====================================================================
    // next state
    always_comb begin
        next_r = r;
        // apb: one wait state, data and error set with pready
        next_r.pready = ap_access;
        next_r.pslverr = ap_access && !addr_ok(paddr);
        if (ap_access) begin
            next_r.prdata = addr_ok(paddr) ? rd_word : 32'h0000_0000;
        end
        if (ap_write) begin
            case (paddr)
                hsc_pkg::OFF_CONFIG: next_r.cfg = pwdata[hsc_pkg::CFG_W-1:0];
                hsc_pkg::OFF_CTRL_IMAGE: next_r.image = pwdata[hsc_pkg::CTRL_W-1:0];
                hsc_pkg::OFF_CTRL_DIRECT: next_r.ctl = pwdata[hsc_pkg::CTRL_W-1:0];
                hsc_pkg::OFF_COMMIT: next_r.ctl = r.image;
                hsc_pkg::OFF_PRESET32: next_r.preset32 = pwdata;
                hsc_pkg::OFF_PRESET16: next_r.preset16 = pwdata;
                hsc_pkg::OFF_HOME_VALUE: next_r.home_val = pwdata;
                default: next_r.cfg = r.cfg;
            endcase
        end

        // two-stage synchroniser, third stage for edges
        next_r.sync1 = {home_switch_input, marker_pulse_input, pulse_input_b, pulse_input_a};
        next_r.sync2 = r.sync1;
        next_r.prev = r.sync2;

        // quadrature value: strobe over marker over counting
        next_r.strobe_prev = r.ctl[hsc_pkg::CTRL_HOME_STROBE];
        if (r.ctl[hsc_pkg::CTRL_HOME_STROBE] && !r.strobe_prev) begin
            next_r.quad = r.home_val;
        end else if (marker_hit) begin
            next_r.quad = r.home_val;
            next_r.loaded = 1'b1;
        end else if (step) begin
            next_r.quad = step_up ? r.quad + 32'h0000_0001 : r.quad - 32'h0000_0001;
        end

        // homing done holds until the window opens again
        next_r.win_prev = window;
        if (marker_hit) begin
            next_r.complete = 1'b1;
        end else if (window && !r.win_prev) begin
            next_r.complete = 1'b0;
        end

        // zero flag: set wins over acknowledge
        next_r.ack_prev = r.ctl[hsc_pkg::CTRL_ZERO_ACK];
        if (r.ctl[hsc_pkg::CTRL_ZERO_ACK] && !r.ack_prev) begin
            next_r.zero = 1'b0;
        end
        if (next_r.quad == 32'h0000_0000 && next_r.quad != r.quad) begin
            next_r.zero = 1'b1;
        end

        // compare pulses gated by interrupt enables; the quadrature path has none
        next_r.irq = {c16b_if.cmp, c16a_if.cmp, c32_if.cmp}
            & r.cfg[hsc_pkg::CFG_IRQ_EN_LSB +: 3];
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.cfg <= hsc_pkg::CFG_RESET;
            r.image <= hsc_pkg::CTRL_RESET;
            r.ctl <= hsc_pkg::CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign cmp_irq = r.irq;

    // =====================================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // cycles spent in quadrature mode, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_cnt <= 3'h0;
        end else if (mode != hsc_pkg::HSC_MODE_QUAD) begin
            armed_cnt <= 3'h0;
        end else if (armed_cnt != 3'h7) begin
            armed_cnt <= armed_cnt + 3'h1;
        end
    end

    chk_pready_pulse: assert property (r.pready |=> !r.pready)
        else $error("pready held longer than one cycle");
    chk_image_held: assert property (ap_write && paddr == hsc_pkg::OFF_CTRL_IMAGE
        |=> $stable(r.ctl))
        else $error("image write reached live controls");
    chk_commit_copy: assert property (ap_write && paddr == hsc_pkg::OFF_COMMIT
        |=> r.ctl == $past(r.image))
        else $error("commit did not copy the image");
    chk_quad_silent: assert property (armed_cnt == 3'h7 |-> r.irq == 3'h0)
        else $error("interrupt in quadrature mode");
    chk_home_strobe: assert property (r.ctl[hsc_pkg::CTRL_HOME_STROBE] && !r.strobe_prev
        |=> r.quad == $past(r.home_val))
        else $error("home strobe did not load value");
    chk_zero_flag: assert property ($changed(r.quad) && r.quad == 32'h0000_0000 |-> r.zero)
        else $error("zero not flagged");
    chk_marker_load: assert property (marker_hit |=> r.quad == $past(r.home_val)
        && r.complete && r.loaded)
        else $error("marker in window did not load");
    chk_sync_edge: assert property ($rose(pulse_input_a) ##1 r.sync1[hsc_pkg::PIN_A]
        [*2] |-> rise[hsc_pkg::PIN_A])
        else $error("input edge not seen after sync");
    chk_irq_gate: assert property (c32_if.cmp && r.cfg[hsc_pkg::CFG_IRQ_EN_LSB]
        |=> r.irq[0] ##1 !r.irq[0])
        else $error("enabled compare did not raise request");

    // apb answers
    chk_ready_answer: assert property (ap_access && addr_ok(paddr)
        |=> r.pready && r.prdata == $past(rd_word))
        else $error("read data wrong");
    chk_err_unmapped: assert property (ap_access && !addr_ok(paddr)
        |=> r.pslverr && r.prdata == 32'h0000_0000)
        else $error("unmapped not refused");
    chk_err_quiet: assert property (r.pslverr |-> r.pready)
        else $error("error without ready");
    chk_direct_write: assert property (ap_write && paddr == hsc_pkg::OFF_CTRL_DIRECT
        |=> r.ctl == $past(pwdata[hsc_pkg::CTRL_W-1:0]))
        else $error("direct write missed");

    // counter gating
    chk_c32_gate: assert property (!r.cfg[hsc_pkg::CFG_EN_LSB] |-> !c32_if.en)
        else $error("counter ungated");
    chk_c16_mode: assert property (mode != hsc_pkg::HSC_MODE_C16
        |-> !c16a_if.en && !c16b_if.en)
        else $error("wrong-mode count");
    chk_irq_masked: assert property (r.cfg[hsc_pkg::CFG_IRQ_EN_LSB +: 3] == 3'h0
        |=> r.irq == 3'h0)
        else $error("masked request");

    // quadrature and homing
    chk_quad_idle: assert property (!r.ctl[hsc_pkg::CTRL_QUAD_RUN] && !marker_hit
        && !(r.ctl[hsc_pkg::CTRL_HOME_STROBE] && !r.strobe_prev) |=> $stable(r.quad))
        else $error("quad moved");
    chk_load_once: assert property (r.loaded && !r.cfg[hsc_pkg::CFG_REPEAT] && !step
        && !(r.ctl[hsc_pkg::CTRL_HOME_STROBE] && !r.strobe_prev) |=> $stable(r.quad))
        else $error("repeat load");
    chk_zero_ack: assert property (r.ctl[hsc_pkg::CTRL_ZERO_ACK] && !r.ack_prev
        |=> !r.zero || $changed(r.quad))
        else $error("zero not cleared");
    chk_done_hold: assert property (r.complete && !(window && !r.win_prev)
        |=> r.complete)
        else $error("done dropped");

    cov_commit: cover property (ap_write && paddr == hsc_pkg::OFF_COMMIT);
    cov_c32_irq: cover property (r.irq[0]);
    cov_homing: cover property (marker_hit ##[1:50] r.zero);
endmodule : hsc_top
`default_nettype wire

// file: hsc_enc_model.sv
// partner model: pulse transmitter and quadrature encoder with marker and home switch
// assumes the bench calls its tasks and that pclk is the unit clock
`timescale 1ns/1ns
`default_nettype none
module hsc_enc_model (
    input wire logic pclk,
    output logic pulse_input_a,
    output logic pulse_input_b,
    output logic marker_pulse_input,
    output logic home_switch_input
);
    // =====================================================================
    // line state, all lines low at start, each line keeps its last level when idle
    logic [3:0] pin = 4'h0;
    logic [1:0] s = 2'h0;
    int half = 4; // cycles per level, at least 3
    assign pulse_input_a = pin[0];
    assign pulse_input_b = pin[1];
    assign marker_pulse_input = pin[2];
    assign home_switch_input = pin[3];

    // =====================================================================
    // n high-low pulses on line k, high held half cycles, low held half plus one
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge pclk);
            pin[k] <= 1'b1;
            repeat (half) @(posedge pclk);
            pin[k] <= 1'b0;
            repeat (half) @(posedge pclk);
        end
    endtask : pulse

    // quadrature steps, tracks a quarter period apart, a leads when up
    task automatic step(input logic up, input int n);
        repeat (n) begin
            @(posedge pclk);
            s = up ? s + 2'h1 : s - 2'h1;
            pin[1:0] <= {s[1], s[1] ^ s[0]};
            repeat (half) @(posedge pclk);
        end
    endtask : step

    // home switch level
    task automatic home(input logic v);
        @(posedge pclk);
        pin[3] <= v;
    endtask : home
endmodule : hsc_enc_model
`default_nettype wire

// file: high_speed_pulse_counters_tb.sv
// self-checking bench of the pulse counter unit over apb
// assumes hsc_pkg, hsc_top and the encoder model are compiled first
`timescale 1ns/1ns
`default_nettype none
module high_speed_pulse_counters_tb;
    // =====================================================================
    // signals, counters and result notes
    typedef struct packed {logic err; logic [31:0] msk; logic [31:0] dat;} hsc_note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] cmp_irq;
    logic pin_a, pin_b, pin_m, pin_h;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] hv;
    hsc_note_t nt;
    hsc_note_t rq[$];
    logic [2:0] iq[$];

    always #5 pclk = ~pclk;

    hsc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_input_a(pin_a),
        .pulse_input_b(pin_b), .marker_pulse_input(pin_m),
        .home_switch_input(pin_h), .cmp_irq(cmp_irq));
    hsc_enc_model i_enc (.pclk(pclk), .pulse_input_a(pin_a), .pulse_input_b(pin_b),
        .marker_pulse_input(pin_m), .home_switch_input(pin_h));

    // =====================================================================
    // compare, verdict and bus tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic dir, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= dir;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] m = 32'hFFFF_FFFF, input logic e = 1'b0);
        rq.push_back('{e, m, d});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // =====================================================================
    // monitors: read data and compare pulses against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (rq.size() == 0) begin
                n_mismatch++;
            end else begin
                nt = rq.pop_front();
                check(prdata & nt.msk, nt.dat);
                check({31'h0, pslverr}, {31'h0, nt.err});
            end
        end
        if (presetn && cmp_irq !== 3'h0) begin
            if (iq.size() == 0) begin
                n_mismatch++;
            end else begin
                check({29'h0, cmp_irq}, {29'h0, iq.pop_front()});
            end
        end
    end

    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // =====================================================================
    // main sequence
    initial begin
        void'($urandom(52618));
        i_enc.half = 3 + ($urandom % 4);
        hv = 32'h100 + ($urandom % 256);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, unmapped place
        rd(hsc_pkg::OFF_CONFIG, 32'h0);
        rd(hsc_pkg::OFF_STATUS, 32'h0);
        wr(12'h0FC, 32'hFF);
        rd(12'h0FC, 32'h0, 32'hFFFF_FFFF, 1'b1);
        // 32-bit counter: up with wrap, then capture and down
        wr(hsc_pkg::OFF_PRESET32, 32'h3);
        wr(hsc_pkg::OFF_CONFIG, 32'h84);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h1);
        iq.push_back(3'h1);
        i_enc.pulse(0, 5);
        rd(hsc_pkg::OFF_VALUE32, 32'h1);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h3);
        i_enc.pulse(0, 1);
        rd(hsc_pkg::OFF_VALUE32, 32'h2);
        wr(hsc_pkg::OFF_CONFIG, 32'h80);
        i_enc.pulse(0, 1);
        rd(hsc_pkg::OFF_VALUE32, 32'h2);
        wr(hsc_pkg::OFF_CONFIG, 32'h84);
        rd(hsc_pkg::OFF_VALUE32, 32'h0);
        iq.push_back(3'h1);
        iq.push_back(3'h1);
        i_enc.pulse(0, 5);
        rd(hsc_pkg::OFF_VALUE32, 32'h3);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h2);
        i_enc.pulse(0, 2);
        rd(hsc_pkg::OFF_VALUE32, 32'h3);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h6);
        rd(hsc_pkg::OFF_VALUE32, 32'h0);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h1);
        i_enc.pulse(0, 2);
        wr(hsc_pkg::OFF_CTRL_IMAGE, 32'h5);
        rd(hsc_pkg::OFF_VALUE32, 32'h2);
        wr(hsc_pkg::OFF_COMMIT, 32'h0);
        rd(hsc_pkg::OFF_VALUE32, 32'h0);
        wr(hsc_pkg::OFF_VALUE32, 32'hFF);
        rd(hsc_pkg::OFF_VALUE32, 32'h0);
        // two 16-bit counters, second one's compare masked
        wr(hsc_pkg::OFF_PRESET16, 32'h0001_0002);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h48);
        wr(hsc_pkg::OFF_CONFIG, 32'h119);
        iq.push_back(3'h2);
        i_enc.pulse(0, 2);
        i_enc.pulse(1, 1);
        rd(hsc_pkg::OFF_VALUE16, 32'h0001_0002);
        rd(hsc_pkg::OFF_VALUE32, 32'h0);
        // quadrature: decode, home load, zero flag
        wr(hsc_pkg::OFF_CONFIG, 32'h2);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h1000);
        i_enc.step(1'b1, 8);
        rd(hsc_pkg::OFF_QUAD_VALUE, 32'h8);
        i_enc.step(1'b0, 3);
        rd(hsc_pkg::OFF_QUAD_VALUE, 32'h5);
        wr(hsc_pkg::OFF_HOME_VALUE, 32'h2);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h1200);
        rd(hsc_pkg::OFF_QUAD_VALUE, 32'h2);
        i_enc.step(1'b0, 2);
        rd(hsc_pkg::OFF_STATUS, 32'h1, 32'h1);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h1400);
        rd(hsc_pkg::OFF_STATUS, 32'h0, 32'h1);
        // marker loads: once, repeat, window from program bit or switch
        wr(hsc_pkg::OFF_HOME_VALUE, hv);
        wr(hsc_pkg::OFF_CONFIG, 32'h42);
        wr(hsc_pkg::OFF_CTRL_DIRECT, 32'h1800);
        rd(hsc_pkg::OFF_STATUS, 32'h2, 32'h6);
        i_enc.pulse(2, 1);
        rd(hsc_pkg::OFF_QUAD_VALUE, hv);
        rd(hsc_pkg::OFF_STATUS, 32'h4, 32'h6);
        i_enc.step(1'b1, 4);
        i_enc.pulse(2, 1);
        rd(hsc_pkg::OFF_QUAD_VALUE, hv + 32'h4);
        wr(hsc_pkg::OFF_CONFIG, 32'h62);
        i_enc.pulse(2, 1);
        rd(hsc_pkg::OFF_QUAD_VALUE, hv);
        wr(hsc_pkg::OFF_CONFIG, 32'h22);
        i_enc.step(1'b1, 1);
        i_enc.pulse(2, 1);
        rd(hsc_pkg::OFF_QUAD_VALUE, hv + 32'h1);
        i_enc.home(1'b1);
        i_enc.pulse(2, 1);
        rd(hsc_pkg::OFF_QUAD_VALUE, hv);
        // leftover notes mean a missing result
        repeat (4) @(posedge pclk);
        if (rq.size() != 0 || iq.size() != 0) begin
            n_mismatch++;
        end
        end_sim();
    end
endmodule : high_speed_pulse_counters_tb
`default_nettype wire
